// ==== verilog/lpeps_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module lpeps_top #(
  parameter int unsigned CYC_PER_MS_P = lpeps_pkg::CYC_PER_MS
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   psmEn,
  input  wire logic [31:0]            activeMs,
  input  wire logic [31:0]            periodMs,
  input  wire lpeps_pkg::lpeps_edrx_t edrxWant,
  input  wire lpeps_pkg::lpeps_ans_t  netAnswer,
  input  wire logic                   netRelease,
  input  wire logic                   pageHit,
  input  wire logic                   hostWake,
  output var  lpeps_pkg::lpeps_state_t state,
  output var  lpeps_pkg::lpeps_edrx_t edrxOffer,
  output logic                        edrxOn,
  output logic                        reachable,
  output logic                        poActive,
  output logic                        calWake,
  output logic                        radioOn,
  output logic                        contactReq,
  output logic                        tauReq
);
  import lpeps_pkg::*;

  lpeps_state_t state_q;
  logic [31:0]  tickCnt_q;
  logic         msTick;
  logic [31:0]  activeCnt_q, periodCnt_q, cycCnt_q, sinceCal_q, calWin_q;
  logic [3:0]   ptwPo_q;
  logic [31:0]  cycleMs_q;
  logic         edrxOn_q, contact_q, tau_q;
  logic [1:0]   ramp_q, extraCal_q;
  logic [31:0]  effCycle, ptwMs;
  logic         actExpire, perExpire, cycEnd, calFire, wakeNet;

  // Millisecond tick; the divider is a parameter so simulation can shorten it.
  always_ff @(posedge clk) begin
    if (rst || tickCnt_q == CYC_PER_MS_P - 1) begin
      tickCnt_q <= 32'h0;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h1;
    end
  end
  assign msTick = (tickCnt_q == CYC_PER_MS_P - 1);

  // Cycle in use: ramp steps after an update, never longer than the negotiated one.
  always_comb begin
    effCycle = edrxOn_q ? cycleMs_q : DRX_MS;
    if (edrxOn_q && ramp_q == 2'h0 && effCycle > RAMP1_MS) begin
      effCycle = RAMP1_MS;
    end else if (edrxOn_q && ramp_q == 2'h1 && effCycle > RAMP2_MS) begin
      effCycle = RAMP2_MS;
    end else if (edrxOn_q && ramp_q == 2'h2 && effCycle > RAMP3_MS) begin
      effCycle = RAMP3_MS;
    end
    ptwMs = edrxOn_q ? 32'(ptwPo_q) * PO_MS : PO_MS;
  end

  assign actExpire = msTick && (activeCnt_q + 32'h1 >= activeMs);
  assign perExpire = msTick && (periodCnt_q + 32'h1 >= periodMs);
  assign cycEnd    = msTick && (cycCnt_q + 32'h1 >= effCycle);
  // A page only counts inside an occasion; the host may ask for access any time.
  assign wakeNet   = hostWake || (poActive && pageHit);

  // Power state sequence.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_CONN;
    end else begin
      case (state_q)
        ST_CONN: begin
          if (netRelease) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (wakeNet) begin
            state_q <= ST_CONN;
          end else if (psmEn && actExpire) begin
            state_q <= ST_DORM;
          end
        end
        ST_DORM: begin
          if (hostWake || perExpire) begin
            state_q <= ST_CONN;
          end
        end
        default: state_q <= ST_CONN;
      endcase
    end
  end

  // Contact and update pulses. A wake while connected is already served, so no second contact.
  always_ff @(posedge clk) begin
    if (rst) begin
      contact_q <= 1'b0;
      tau_q     <= 1'b0;
    end else begin
      contact_q <= (state_q == ST_IDLE && wakeNet) || (state_q == ST_DORM && (hostWake || perExpire));
      tau_q     <= state_q == ST_DORM && perExpire && !hostWake;
    end
  end

  // Active and periodic timers both start when idle is entered.
  always_ff @(posedge clk) begin
    if (rst || state_q == ST_CONN) begin
      activeCnt_q <= 32'h0;
      periodCnt_q <= 32'h0;
    end else if (msTick) begin
      activeCnt_q <= activeCnt_q + 32'h1;
      // periodic timer spans idle and dormant
      periodCnt_q <= periodCnt_q + 32'h1;
    end
  end

  // Negotiation: offer what is wanted, use what the network allows.
  always_ff @(posedge clk) begin
    if (rst) begin
      edrxOffer <= '0;
      edrxOn_q  <= 1'b0;
      ptwPo_q   <= 4'h1;
      cycleMs_q <= DRX_MS;
    end else begin
      edrxOffer <= edrxWant;
      if (netAnswer.valid) begin
        edrxOn_q <= edrxWant.en && netAnswer.allowed;
        if (netAnswer.allowed) begin
          ptwPo_q   <= netAnswer.ptwPo;
          cycleMs_q <= netAnswer.cycleMs;
        end
      end
    end
  end

  // Position within the cycle; the paging window sits at its start.
  // window then low power
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_IDLE || cycEnd) begin
      cycCnt_q <= 32'h0;
    end else if (msTick) begin
      cycCnt_q <= cycCnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_q <= RAMP_DONE;
    end else if (tau_q) begin
      ramp_q <= 2'h0;
    end else if (state_q == ST_IDLE && cycEnd && ramp_q != RAMP_DONE) begin
      ramp_q <= ramp_q + 2'h1;
    end
  end

  // Calibration: extra wakes after release, and while idle never more than 81.92 s without one.
  // The paging window also calibrates, so it restarts the count once the extra wakes are done.
  // While extra wakes are pending the window does not restart the count, else short cycles would starve them.
  // A wake is held off at a cycle end and inside the window, so it never overlaps an occasion.
  assign calFire = state_q == ST_IDLE && msTick && calWin_q == 32'h0 && !poActive && !cycEnd &&
                   ((sinceCal_q + 32'h1 >= CAL_MAX_MS) || (extraCal_q != 2'h0 && sinceCal_q + 32'h1 >= CAL_GAP_MS));
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_IDLE || calFire || ((poActive || cycEnd) && extraCal_q == 2'h0)) begin
      sinceCal_q <= 32'h0;
    end else if (msTick) begin
      sinceCal_q <= sinceCal_q + 32'h1;
    end
  end
  // A cycle end cuts a running wake, so the next window starts with the radio free of it.
  always_ff @(posedge clk) begin
    if (rst || state_q != ST_IDLE || cycEnd) begin
      calWin_q <= 32'h0;
    end else if (calFire) begin
      calWin_q <= CAL_MS;
    end else if (msTick && calWin_q != 32'h0) begin
      calWin_q <= calWin_q - 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      extraCal_q <= 2'h0;
    end else if (state_q == ST_CONN && netRelease) begin
      extraCal_q <= EXTRA_CALS;
    end else if (calFire && extraCal_q != 2'h0) begin
      extraCal_q <= extraCal_q - 2'h1;
    end
  end

  // Outputs. Occasions are monitored only inside the window of the cycle in use.
  assign state      = state_q;
  assign edrxOn     = edrxOn_q;
  assign poActive   = state_q == ST_IDLE && cycCnt_q < ptwMs;
  assign calWake    = calWin_q != 32'h0;
  assign reachable  = state_q != ST_DORM;
  assign radioOn    = state_q == ST_CONN || poActive || calWake;
  assign contactReq = contact_q;
  assign tauReq     = tau_q;

  // Checks.
  dorm_entry_a : assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_DORM && $past(state_q) != ST_DORM) |-> $past(state_q) == ST_IDLE && $past(actExpire))
    else $error("Dormant entered before the active timer ran out.");
  dorm_unreach_a : assert property (@(posedge clk) disable iff (rst)
    state_q == ST_DORM |-> !reachable && !radioOn)
    else $error("Dormant device is reachable.");
  idle_restart_a : assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && $past(state_q) != ST_IDLE) |-> $past(state_q) == ST_CONN && activeCnt_q == 32'h0)
    else $error("Idle entered without a fresh active timer.");
  host_wake_a : assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_DORM && hostWake) |=> state_q == ST_CONN && contactReq && !tauReq)
    else $error("Host wake did not contact the network.");
  period_tau_a : assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_DORM && perExpire && !hostWake) |=> tauReq ##1 (ramp_q == 2'h0))
    else $error("Periodic expiry did not send an update.");
  merged_wake_a : assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_CONN && hostWake) |=> !contactReq)
    else $error("Second contact started during a wake.");
  page_conn_a : assert property (@(posedge clk) disable iff (rst)
    (poActive && pageHit) |=> state_q == ST_CONN && contactReq)
    else $error("Page in an occasion did not connect.");
  answer_use_a : assert property (@(posedge clk) disable iff (rst)
    (netAnswer.valid && netAnswer.allowed && edrxWant.en) |=> edrxOn && cycleMs_q == $past(netAnswer.cycleMs))
    else $error("Answered values not adopted.");
  cal_bound_a : assert property (@(posedge clk) disable iff (rst)
    state_q == ST_IDLE |-> sinceCal_q < CAL_MAX_MS)
    else $error("Calibration gap exceeded.");
  po_idle_a : assert property (@(posedge clk) disable iff (rst)
    poActive |-> state_q == ST_IDLE && !calWake)
    else $error("Occasion monitored outside idle window.");

endmodule // lpeps_top
`default_nettype wire

// ==== verilog/lpeps_pkg.sv ====
`default_nettype none
package lpeps_pkg;

  // Clock and the millisecond time base.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // Times in milliseconds.
  localparam logic [31:0] RAMP1_MS    = 32'h0000_2710;  // 10 s.
  localparam logic [31:0] RAMP2_MS    = 32'h0000_4e20;  // 20 s.
  localparam logic [31:0] RAMP3_MS    = 32'h0000_9c40;  // 40 s.
  localparam logic [31:0] CAL_MAX_MS  = 32'h0001_4000;  // 81.92 s.
  localparam logic [31:0] CAL_GAP_MS  = 32'h0000_03e8;  // Spacing of extra calibrations.
  localparam logic [31:0] PO_MS       = 32'h0000_000a;  // One paging occasion.
  localparam logic [31:0] CAL_MS      = 32'h0000_0002;  // One calibration wake.
  localparam logic [31:0] DRX_MS      = 32'h0000_0500;  // Plain cycle while extended mode is off.
  localparam logic [1:0]  EXTRA_CALS  = 2'h3;
  localparam logic [1:0]  RAMP_DONE   = 2'h3;

  typedef enum logic [2:0] {
    ST_CONN = 3'h1,
    ST_IDLE = 3'h2,
    ST_DORM = 3'h4
  } lpeps_state_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  ptwPo;
    logic [31:0] cycleMs;
  } lpeps_edrx_t;

  typedef struct packed {
    logic        valid;
    logic        allowed;
    logic [3:0]  ptwPo;
    logic [31:0] cycleMs;
  } lpeps_ans_t;

endpackage : lpeps_pkg
`default_nettype wire

// ==== tb/lpeps_net_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lpeps_net_model #(
  parameter int unsigned REL_GAP = 6,
  parameter logic [3:0]  ANS_PTW = 4'h2,
  parameter logic [31:0] ANS_CYC = 32'h0000_0064
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   conn,
  input  wire lpeps_pkg::lpeps_edrx_t offer,
  output var  lpeps_pkg::lpeps_ans_t  answer,
  output logic                        netRelease
);
  import lpeps_pkg::*;
  logic [3:0] connCnt_q;
  logic       offEn_q;

  // The network ends each connected spell after a short fixed time.
  // registration kept throughout
  always_ff @(posedge clk) begin
    if (rst || !conn) begin
      connCnt_q <= 4'h0;
    end else if (connCnt_q != 4'hf) begin
      connCnt_q <= connCnt_q + 4'h1;
    end
  end
  assign netRelease = (connCnt_q == REL_GAP[3:0]);

  // Answer a new offer once, with values that differ from those asked for.
  // adjusted values answered
  always_ff @(posedge clk) begin
    offEn_q <= !rst && offer.en;
    answer  <= '0;
    if (!rst && offer.en && !offEn_q) begin
      answer <= '{valid: 1'b1, allowed: 1'b1, ptwPo: ANS_PTW, cycleMs: ANS_CYC};
    end
  end
endmodule // lpeps_net_model
`default_nettype wire

// ==== tb/test_lpeps_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_lpeps_top;
  import lpeps_pkg::*;
  localparam int unsigned CPM = 4;  // Short millisecond so the run stays brief.
  logic         clk = 1'b0, rst = 1'b1, psmEn = 1'b0, pageHit = 1'b0, hostWake = 1'b0;
  logic [31:0]  activeMs = 32'h0000_0005, periodMs = 32'h0000_0014;
  lpeps_edrx_t  edrxWant = '0, edrxOffer;
  lpeps_ans_t   netAnswer;
  lpeps_state_t state;
  logic         netRelease, edrxOn, reachable, poActive, calWake, radioOn, contactReq, tauReq;
  int           mismatches = 0, tests_run = 0, cycles = 0, n, t0;

  // Free running clock of 50 ns.
  always #25 clk = ~clk;

  lpeps_top #(.CYC_PER_MS_P(CPM)) lpeps_top_i (.clk(clk), .rst(rst), .psmEn(psmEn), .activeMs(activeMs),
    .periodMs(periodMs), .edrxWant(edrxWant), .netAnswer(netAnswer), .netRelease(netRelease),
    .pageHit(pageHit), .hostWake(hostWake), .state(state), .edrxOffer(edrxOffer), .edrxOn(edrxOn),
    .reachable(reachable), .poActive(poActive), .calWake(calWake), .radioOn(radioOn),
    .contactReq(contactReq), .tauReq(tauReq));
  lpeps_net_model lpeps_net_model_i (.clk(clk), .rst(rst), .conn(state == ST_CONN), .offer(edrxOffer),
    .answer(netAnswer), .netRelease(netRelease));

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a state, so a stuck sequencer cannot hang the run.
  task automatic waitSt(input lpeps_state_t s, input int lim);
    n = 0;
    while (state !== s && n < lim) begin
      n++;
      @(negedge clk);
    end
    chk(state, s);
  endtask

  // Measures how many cycles a window output stays high.
  task automatic lenOf(input logic cal);
    n = 0;
    while ((cal ? calWake : poActive) === 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic wake();
    hostWake = 1'b1;
    @(negedge clk);
    hostWake = 1'b0;
  endtask

  task automatic t_reset();
    chk({state, reachable, radioOn, contactReq, edrxOn}, {ST_CONN, 4'hc});
  endtask

  task automatic t_cal();
    waitSt(ST_IDLE, 20);
    lenOf(1'b0);
    chk(n >= 36 && n <= 44, 1'b1);
    n = 0;
    while (calWake !== 1'b1 && n < 6000) begin
      n++;
      @(negedge clk);
    end
    chk({calWake, radioOn}, 2'h3);
    lenOf(1'b1);
    chk(n >= 4 && n < 10 * CPM, 1'b1);
  endtask

  task automatic t_edrx();
    edrxWant = '{en: 1'b1, ptwPo: 4'h4, cycleMs: 32'h0000_0200};
    @(negedge clk);
    chk(edrxOffer, edrxWant);
    repeat (4) @(negedge clk);
    chk(edrxOn, 1'b1);
  endtask

  task automatic t_page();
    wake();
    chk({state, contactReq}, {ST_CONN, 1'b1});
    @(negedge clk);
    wake();
    chk(contactReq, 1'b0);
    waitSt(ST_IDLE, 20);
    lenOf(1'b0);
    chk(n >= 76 && n <= 84, 1'b1);
    // The page is held pending, as the network keeps it for the next occasion.
    pageHit = 1'b1;
    repeat (40) @(negedge clk);
    chk(state, ST_IDLE);
    t0 = cycles;
    waitSt(ST_CONN, 600);
    chk(cycles - t0 >= 240, 1'b1);
    pageHit = 1'b0;
  endtask

  task automatic t_psm();
    psmEn = 1'b1;
    waitSt(ST_IDLE, 20);
    repeat (16) @(negedge clk);
    chk({state, reachable}, {ST_IDLE, 1'b1});
    waitSt(ST_DORM, 8);
    chk(reachable, 1'b0);
    wake();
    chk({state, contactReq, tauReq}, {ST_CONN, 2'h2});
    waitSt(ST_IDLE, 20);
    t0 = cycles;
    waitSt(ST_DORM, 24);
    n = 0;
    while (contactReq !== 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    chk({tauReq, cycles - t0 >= 76}, 2'h3);
  endtask

  // Main sequence; inputs change on the falling edge only.
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_cal();
    t_edrx();
    t_page();
    t_psm();
    summarize();
  end

  // Hang guard, well above the few thousand cycles the sequence needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
endmodule // test_lpeps_top
`default_nettype wire
